// File: tb/pcm_counter_tb.sv
// self-checking bench of the counter channel
`timescale 1ns/1ps
module pcm_counter_tb;
  logic mclk, rst_n, wr_en, rd_en, gate, glvl, cnt_out, irq;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, v, v2;
  int miscompares, compares, cyc, n, n3, i;
  typedef struct {logic [7:0] a; logic [15:0] e;} pcm_row_t;
  pcm_row_t rows[7];

  pcm_counter pcm_counter_inst (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .gate(gate), .cnt_out(cnt_out), .irq(irq));
  pcm_gate_src pcm_gate_src_inst (.mclk(mclk), .rst_n(rst_n), .lvl(glvl),
    .gate(gate));

  // ==========================================================
  // clock, watchdog and helpers
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      results();
    end
  end

  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] s, e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  // clocks until the output shows lv, lim plus one if it never does
  task automatic wl(input logic lv, input int lim, output int c);
    c = 0;
    do begin
      @(posedge mclk);
      #1 c++;
    end while (cnt_out !== lv && c <= lim);
  endtask

  task automatic gt(input logic l);
    @(posedge mclk);
    glvl <= l;
  endtask

  task automatic trig();
    gt(1'b0);
    repeat (3) @(posedge mclk);
    glvl <= 1'b1;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    glvl = 1'b1;
    rows = '{'{pcm_pkg::OFF_CTRL, 16'h0000}, '{pcm_pkg::OFF_IRQ, 16'h0000},
      '{pcm_pkg::OFF_MASK, 16'h0000}, '{pcm_pkg::OFF_CE, 16'h0000},
      '{pcm_pkg::OFF_HOLD, 16'h0000}, '{8'h1C, 16'h0000},
      '{pcm_pkg::OFF_STAT, 16'h0011}};
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 7; i++) begin
      rd(rows[i].a, v);
      chk("reg", v, rows[i].e);
    end
    // software strobe, single low byte, count 5
    wr(pcm_pkg::OFF_CTRL, 16'h0018);
    wr(pcm_pkg::OFF_CNT, 16'h0005);
    wl(1'b0, 20, n);
    chk("m4 lat", 16'(n), 16'h0006);
    wl(1'b1, 5, n);
    chk("m4 width", 16'(n), 16'h0001);
    wr(pcm_pkg::OFF_CTRL, 16'h0038);
    wr(pcm_pkg::OFF_CNT, 16'h0004);
    wl(1'b0, 10, n);
    chk("m4 byte1", 16'(n), 16'h000B);
    wr(pcm_pkg::OFF_CNT, 16'h0001);
    wl(1'b0, 300, n);
    chk("m4 16bit", 16'(n), 16'h0105);
    // a lone first byte while counting must leave the count alone
    wr(pcm_pkg::OFF_CNT, 16'h0007);
    rd(pcm_pkg::OFF_HOLD, v);
    chk("hold", v, 16'h0104);
    wr(pcm_pkg::OFF_CTRL, 16'h0018);
    wr(pcm_pkg::OFF_CNT, 16'h0008);
    repeat (3) @(posedge mclk);
    wr(pcm_pkg::OFF_CNT, 16'h0003);
    wl(1'b0, 20, n);
    chk("m4 reload", 16'(n), 16'h0004);
    wr(pcm_pkg::OFF_CTRL, 16'h0028);
    wr(pcm_pkg::OFF_CNT, 16'h0001);
    rd(pcm_pkg::OFF_HOLD, v);
    chk("hold hi", v, 16'h0100);
    gt(1'b0);
    wr(pcm_pkg::OFF_CTRL, 16'h0018);
    wr(pcm_pkg::OFF_CNT, 16'h0004);
    wl(1'b0, 20, n);
    chk("m4 gate lo", 16'(n), 16'h0015);
    rd(pcm_pkg::OFF_CE, v);
    chk("m4 frozen", v, 16'h0004);
    gt(1'b1);
    wl(1'b0, 20, n);
    chk("m4 gate hi", 16'(n >= 5 && n <= 12), 16'h0001);
    // interrupt status, mask and clear
    chk("irq masked", 16'(irq), 16'h0000);
    rd(pcm_pkg::OFF_IRQ, v);
    chk("irq stat", 16'(v[0]), 16'h0001);
    wr(pcm_pkg::OFF_MASK, 16'h0001);
    repeat (2) @(posedge mclk);
    #1 chk("irq on", 16'(irq), 16'h0001);
    wr(pcm_pkg::OFF_IRQ, 16'h0003);
    repeat (2) @(posedge mclk);
    #1 chk("irq clr", 16'(irq), 16'h0000);
    // hardware strobe
    wr(pcm_pkg::OFF_CTRL, 16'h001A);
    wr(pcm_pkg::OFF_CNT, 16'h0003);
    wl(1'b0, 10, n);
    chk("m5 idle", 16'(n), 16'h000B);
    trig();
    wl(1'b0, 40, n3);
    chk("m5 lat", 16'(n3 >= 4 && n3 <= 10), 16'h0001);
    wr(pcm_pkg::OFF_CNT, 16'h0009);
    trig();
    wl(1'b0, 4, n);
    chk("m5 early", 16'(n), 16'h0005);
    trig();
    wl(1'b0, 60, n);
    chk("m5 retrig", 16'(n - n3), 16'h0006);
    wr(pcm_pkg::OFF_CNT, 16'h0002);
    wl(1'b0, 20, n);
    chk("m5 no load", 16'(n), 16'h0015);
    // retriggerable one-shot
    wr(pcm_pkg::OFF_CTRL, 16'h0012);
    wr(pcm_pkg::OFF_CNT, 16'h0004);
    wl(1'b0, 10, n);
    chk("m1 idle", 16'(n), 16'h000B);
    trig();
    wl(1'b0, 20, n);
    wl(1'b1, 10, n);
    chk("m1 width", 16'(n), 16'h0004);
    // terminal count
    wr(pcm_pkg::OFF_CTRL, 16'h0010);
    wl(1'b0, 3, n);
    chk("m0 ctrl", 16'(n <= 2), 16'h0001);
    wr(pcm_pkg::OFF_CNT, 16'h0004);
    wl(1'b1, 20, n);
    chk("m0 lat", 16'(n), 16'h0005);
    wl(1'b0, 10, n);
    chk("m0 stay", 16'(n), 16'h000B);
    gt(1'b0);
    repeat (3) @(posedge mclk);
    rd(pcm_pkg::OFF_CE, v);
    rd(pcm_pkg::OFF_CE, v2);
    chk("m0 frozen", v2, v);
    gt(1'b1);
    // rate generator and gate override
    wr(pcm_pkg::OFF_CTRL, 16'h0014);
    wr(pcm_pkg::OFF_CNT, 16'h0003);
    wl(1'b0, 20, n);
    chk("m2 lat", 16'(n), 16'h0003);
    wl(1'b1, 5, n);
    chk("m2 low", 16'(n), 16'h0001);
    wl(1'b0, 5, n);
    chk("m2 high", 16'(n), 16'h0002);
    gt(1'b0);
    repeat (5) @(posedge mclk);
    wl(1'b0, 10, n);
    chk("m2 gate lo", 16'(n), 16'h000B);
    gt(1'b1);
    wl(1'b0, 20, n);
    chk("m2 rise", 16'(n >= 4 && n <= 12), 16'h0001);
    // square wave, even then odd
    wr(pcm_pkg::OFF_CTRL, 16'h0016);
    wr(pcm_pkg::OFF_CNT, 16'h0004);
    wl(1'b0, 20, n);
    wl(1'b1, 10, n);
    chk("m3 ev lo", 16'(n), 16'h0002);
    wl(1'b0, 10, n);
    chk("m3 ev hi", 16'(n), 16'h0002);
    wr(pcm_pkg::OFF_CTRL, 16'h0016);
    wr(pcm_pkg::OFF_CNT, 16'h0005);
    wl(1'b0, 20, n);
    wl(1'b1, 10, n);
    chk("m3 od lo", 16'(n), 16'h0002);
    wl(1'b0, 10, n);
    chk("m3 od hi", 16'(n), 16'h0003);
    wr(pcm_pkg::OFF_CTRL, 16'h0008);
    rd(pcm_pkg::OFF_CTRL, v);
    chk("ctrl aw0", v, 16'h0016);
    // decimal count of zero
    gt(1'b0);
    wr(pcm_pkg::OFF_CTRL, 16'h0019);
    wr(pcm_pkg::OFF_CNT, 16'h0000);
    repeat (3) @(posedge mclk);
    rd(pcm_pkg::OFF_CE, v);
    chk("bcd load", v, 16'h0000);
    gt(1'b1);
    repeat (12) @(posedge mclk);
    gt(1'b0);
    repeat (5) @(posedge mclk);
    rd(pcm_pkg::OFF_CE, v);
    chk("bcd wrap", {8'h00, v[15:8]}, 16'h0099);
    // second reset in mid-run
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("rst out", 16'(cnt_out), 16'h0001);
    chk("rst irq", 16'(irq), 16'h0000);
    rst_n <= 1'b1;
    rd(pcm_pkg::OFF_CTRL, v);
    chk("rst ctrl", v, 16'h0000);
    results();
  end
endmodule

// File: tb/pcm_gate_src.sv
// gate source model standing outside the counter channel
`timescale 1ns/1ps
module pcm_gate_src (
  input wire logic mclk,  // system clock
  input wire logic rst_n, // asynchronous reset, low
  input wire logic lvl,   // gate level asked for by the bench
  output logic gate       // gate pin into the counter
);
  // the source is synchronous, so the pin moves just after an edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gate <= 1'b1;
    end else begin
      gate <= lvl;
    end
  end
endmodule

// File: verilog/pcm_counter.sv
// programmable down-counter channel with six counting modes
//
// Operation
// - strobe mode 4: output high, one low clock at zero, keeps counting.
// - mode 4 count write while counting reloads element next clock.
// - mode 4 two-byte access: only the second byte write loads.
// - mode 4 gate high counts, gate low halts, output unaffected.
// - mode 4 output pulse comes N clocks after the load.
// - mode 5 loads only the clock after a gate rise, once armed.
// - mode 5 gate rise mid-count reloads and restarts the sequence.
// - mode 5 count writes wait for trigger; two-byte access needs both bytes first.
// - mode 5 output low N plus one clocks after the gate rise.
// - mode 0 output low on control word or count write, high at zero.
// - mode 2 output low at one, high next clock or gate low.
// - mode 3 toggles at two (even) or zero (odd high), reloading.
// - modes 2 and 3 gate low halts, output high; rise reloads.
// - mode 1 gate rise loads and drives low; high at zero.
// - mode 0 freezes on gate low, first byte of two-byte access or control word write.
// - programmed zero counts as 65536 binary or 10000 decimal.
// - single-byte access clears the byte that was not written.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module pcm_counter (
  input wire logic mclk,           // system clock
  input wire logic rst_n,          // asynchronous reset, low
  input wire logic [7:0] addr,     // register byte address
  input wire logic [15:0] wdata,   // register write data
  input wire logic wr_en,          // write strobe
  input wire logic rd_en,          // read strobe
  output logic [15:0] rdata,       // read data, cycle after strobe
  input wire logic gate,           // gate input
  output logic cnt_out,            // counter output pin
  output logic irq                 // level interrupt
);

  // ==========================================================
  // state
  pcm_pkg::pcm_state_t st_q, st_d;
  logic [15:0] ce_q, ce_d;
  logic [15:0] cr_q, cr_d;
  logic [7:0] lo_q, lo_d;
  logic half_q, half_d;
  logic armed_q, armed_d;
  logic out_q, out_d;
  logic [5:0] cw_q, cw_d;
  logic [1:0] sts_q, sts_d;
  logic [1:0] mask_q, mask_d;
  logic irq_q, irq_d;
  logic [15:0] rdata_q, rdata_d;
  logic [2:0] sync_q, sync_d;
  logic [1:0] ev;
  logic [15:0] dec1, dec2;
  logic cw_wr, cnt_wr, cnt_done, cnt_first;
  logic gate_s, trig, en, odd;
  logic [2:0] mode;
  logic [1:0] aw;

  assign mode = cw_q[pcm_pkg::CW_MODE+:3];
  assign aw = cw_q[pcm_pkg::CW_AW+:2];
  assign cw_wr = wr_en && addr == pcm_pkg::OFF_CTRL &&
                 wdata[pcm_pkg::CW_AW+:2] != pcm_pkg::AW_NONE;
  assign cnt_wr = wr_en && addr == pcm_pkg::OFF_CNT &&
                  aw != pcm_pkg::AW_NONE;
  assign odd = cr_q[0];

  // ==========================================================
  // gate synchroniser and edge detect
  always_comb begin
    sync_d = {sync_q[1:0], gate};
  end

  assign gate_s = sync_q[1];
  assign trig = sync_q[1] && !sync_q[2];

  pcm_dec u_dec (
    .val(ce_q),
    .bcd(cw_q[pcm_pkg::CW_BCD]),
    .dec1(dec1),
    .dec2(dec2)
  );

  function automatic logic gated_mode(input logic [2:0] m);
    return m == pcm_pkg::M_TC || m == pcm_pkg::M_RATE ||
           m == pcm_pkg::M_SQ || m == pcm_pkg::M_SWS;
  endfunction

  function automatic logic trig_mode(input logic [2:0] m);
    return m == pcm_pkg::M_OS || m == pcm_pkg::M_HWS ||
           m == pcm_pkg::M_RATE || m == pcm_pkg::M_SQ;
  endfunction

  assign en = gated_mode(mode) ? gate_s : 1'b1;

  // ==========================================================
  // counting element, output and count port
  always_comb begin
    st_d = st_q;
    ce_d = ce_q;
    cr_d = cr_q;
    lo_d = lo_q;
    half_d = half_q;
    armed_d = armed_q;
    out_d = out_q;
    cw_d = cw_q;
    ev = '0;
    cnt_done = 1'b0;
    cnt_first = 1'b0;
    case (st_q)
      pcm_pkg::ST_LOAD: begin
        st_d = pcm_pkg::ST_RUN;
        if (mode == pcm_pkg::M_SQ) begin
          ce_d = {cr_q[15:1], 1'b0};
        end else begin
          ce_d = cr_q;
        end
        if (mode == pcm_pkg::M_OS) begin
          out_d = 1'b0;
        end
        if (mode != pcm_pkg::M_TC && mode != pcm_pkg::M_OS) begin
          out_d = 1'b1;
        end
      end
      pcm_pkg::ST_RUN: begin
        if (en) begin
          case (mode)
            pcm_pkg::M_TC, pcm_pkg::M_OS: begin
              ce_d = dec1;
              if (dec1 == pcm_pkg::CNT_ZERO) begin
                out_d = 1'b1;
                ev[pcm_pkg::EV_TC] = 1'b1;
              end
            end
            pcm_pkg::M_SWS, pcm_pkg::M_HWS: begin
              ce_d = dec1;
              out_d = dec1 != pcm_pkg::CNT_ZERO;
              ev[pcm_pkg::EV_TC] = dec1 == pcm_pkg::CNT_ZERO;
            end
            pcm_pkg::M_RATE: begin
              if (ce_q == pcm_pkg::CNT_ONE) begin
                ce_d = cr_q;
                out_d = 1'b1;
                ev[pcm_pkg::EV_TC] = 1'b1;
              end else begin
                ce_d = dec1;
                out_d = dec1 != pcm_pkg::CNT_ONE;
              end
            end
            pcm_pkg::M_SQ: begin
              if ((out_q && odd) ? ce_q == pcm_pkg::CNT_ZERO :
                  ce_q == pcm_pkg::CNT_TWO) begin
                out_d = !out_q;
                ce_d = {cr_q[15:1], 1'b0};
                ev[pcm_pkg::EV_TC] = out_q;
              end else begin
                ce_d = dec2;
              end
            end
            default: begin
              ce_d = ce_q;
            end
          endcase
        end else if (mode == pcm_pkg::M_RATE ||
                     mode == pcm_pkg::M_SQ) begin
          out_d = 1'b1;
        end
      end
      default: begin
        if (!gate_s && (mode == pcm_pkg::M_RATE ||
                        mode == pcm_pkg::M_SQ)) begin
          out_d = 1'b1;
        end
      end
    endcase
    if (trig && armed_q && trig_mode(mode)) begin
      st_d = pcm_pkg::ST_LOAD;
      ev[pcm_pkg::EV_TRIG] = 1'b1;
    end
    if (cw_wr) begin
      cw_d = wdata[pcm_pkg::CW_W-1:0];
      st_d = pcm_pkg::ST_IDLE;
      armed_d = 1'b0;
      half_d = 1'b0;
      out_d = wdata[pcm_pkg::CW_MODE+:3] != pcm_pkg::M_TC;
    end else if (cnt_wr) begin
      case (aw)
        pcm_pkg::AW_LOW: begin
          cr_d = {8'h00, wdata[7:0]};
          cnt_done = 1'b1;
        end
        pcm_pkg::AW_HIGH: begin
          cr_d = {wdata[7:0], 8'h00};
          cnt_done = 1'b1;
        end
        default: begin
          if (!half_q) begin
            lo_d = wdata[7:0];
            half_d = 1'b1;
            cnt_first = 1'b1;
          end else begin
            cr_d = {wdata[7:0], lo_q};
            half_d = 1'b0;
            cnt_done = 1'b1;
          end
        end
      endcase
      if (cnt_first && mode == pcm_pkg::M_TC) begin
        st_d = pcm_pkg::ST_IDLE;
        out_d = 1'b0;
      end
      if (cnt_done) begin
        armed_d = 1'b1;
        case (mode)
          pcm_pkg::M_TC: begin
            st_d = pcm_pkg::ST_LOAD;
            out_d = 1'b0;
          end
          pcm_pkg::M_SWS: begin
            st_d = pcm_pkg::ST_LOAD;
          end
          pcm_pkg::M_RATE, pcm_pkg::M_SQ: begin
            if (st_q != pcm_pkg::ST_RUN) begin
              st_d = pcm_pkg::ST_LOAD;
            end
          end
          default: begin
            armed_d = 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // interrupt status, mask and read port
  always_comb begin
    mask_d = mask_q;
    sts_d = sts_q;
    if (wr_en && addr == pcm_pkg::OFF_MASK) begin
      mask_d = wdata[pcm_pkg::EV_W-1:0];
    end
    if (wr_en && addr == pcm_pkg::OFF_IRQ) begin
      sts_d = sts_q & ~wdata[pcm_pkg::EV_W-1:0];
    end
    sts_d = sts_d | ev;
    irq_d = |(sts_d & mask_d);
    rdata_d = 16'h0000;
    if (rd_en) begin
      case (addr)
        pcm_pkg::OFF_CTRL: rdata_d = {10'h000, cw_q};
        pcm_pkg::OFF_STAT: rdata_d = {11'h000, gate_s, armed_q,
                                      st_q, out_q};
        pcm_pkg::OFF_IRQ: rdata_d = {14'h0000, sts_q};
        pcm_pkg::OFF_MASK: rdata_d = {14'h0000, mask_q};
        pcm_pkg::OFF_CE: rdata_d = ce_q;
        pcm_pkg::OFF_HOLD: rdata_d = cr_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= pcm_pkg::ST_IDLE;
      ce_q <= pcm_pkg::RST_CE;
      cr_q <= pcm_pkg::RST_HOLD;
      lo_q <= 8'h00;
      half_q <= 1'b0;
      armed_q <= 1'b0;
      out_q <= pcm_pkg::RST_OUT;
      cw_q <= pcm_pkg::RST_CTRL;
      sts_q <= pcm_pkg::RST_EV;
      mask_q <= pcm_pkg::RST_EV;
      irq_q <= 1'b0;
      rdata_q <= 16'h0000;
      sync_q <= 3'h0;
    end else begin
      st_q <= st_d;
      ce_q <= ce_d;
      cr_q <= cr_d;
      lo_q <= lo_d;
      half_q <= half_d;
      armed_q <= armed_d;
      out_q <= out_d;
      cw_q <= cw_d;
      sts_q <= sts_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      sync_q <= sync_d;
    end
  end

  assign rdata = rdata_q;
  assign cnt_out = out_q;
  assign irq = irq_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_strobe_one_low: assert property (
    $fell(out_q) && mode == pcm_pkg::M_SWS && !cw_wr |=> out_q)
    else $error("mode 4 low pulse longer than one clock");

  a_strobe_reload: assert property (
    cnt_done && mode == pcm_pkg::M_SWS && !trig |=>
      ##1 ce_q == $past(cr_q))
    else $error("mode 4 count write did not reload");

  a_strobe_first_byte: assert property (
    cnt_first && mode == pcm_pkg::M_SWS && st_q == pcm_pkg::ST_RUN
      |=> st_q == pcm_pkg::ST_RUN)
    else $error("mode 4 first byte disturbed counting");

  a_strobe_gate_hold: assert property (
    mode == pcm_pkg::M_SWS && st_q == pcm_pkg::ST_RUN && !gate_s &&
      !cnt_wr && !cw_wr |=> $stable(ce_q) && out_q)
    else $error("mode 4 counted or pulsed with gate low");

  a_hw_trig_load: assert property (
    mode == pcm_pkg::M_HWS && trig && armed_q && !cw_wr |=>
      st_q == pcm_pkg::ST_LOAD ##1 ce_q == $past(cr_q))
    else $error("mode 5 trigger did not load");

  a_hw_no_load: assert property (
    mode == pcm_pkg::M_HWS && !trig |=> st_q != pcm_pkg::ST_LOAD)
    else $error("mode 5 loaded without trigger");

  a_tc_write_low: assert property (
    cnt_done && mode == pcm_pkg::M_TC |=> !out_q ##1 !out_q)
    else $error("mode 0 output not low after count write");

  a_rate_reload: assert property (
    mode == pcm_pkg::M_RATE && st_q == pcm_pkg::ST_RUN && en &&
      ce_q == pcm_pkg::CNT_ONE && !trig && !cw_wr && !cnt_wr
      |-> !out_q ##1 (out_q && ce_q == $past(cr_q)))
    else $error("mode 2 reload at one wrong");

  a_gate_low_high: assert property (
    (mode == pcm_pkg::M_RATE || mode == pcm_pkg::M_SQ) && !gate_s &&
      !cw_wr |=> out_q)
    else $error("modes 2 and 3 output not high with gate low");

  a_oneshot_low: assert property (
    mode == pcm_pkg::M_OS && st_q == pcm_pkg::ST_LOAD && !cw_wr &&
      !trig |=> !out_q && ce_q == $past(cr_q))
    else $error("mode 1 load did not drive output low");

  a_tc_freeze: assert property (
    mode == pcm_pkg::M_TC && !gate_s && st_q == pcm_pkg::ST_RUN &&
      !cnt_wr && !cw_wr |=> $stable(ce_q))
    else $error("mode 0 counted with gate low");

  a_irq_level: assert property (
    irq_q == |(sts_q & mask_q))
    else $error("interrupt does not follow masked status");

  c_strobe_pulse: cover property (
    mode == pcm_pkg::M_SWS && $fell(out_q) ##1 out_q);
  c_hw_trigger: cover property (
    mode == pcm_pkg::M_HWS && trig && armed_q ##2 !out_q);
  c_square_toggle: cover property (
    mode == pcm_pkg::M_SQ && $fell(out_q) ##[1:20] $rose(out_q));

endmodule

// File: verilog/pcm_dec.sv
// binary or four-digit decimal decrement by one and by two
`timescale 1ns/1ps
module pcm_dec (
  input wire logic [15:0] val,   // value to decrement
  input wire logic bcd,          // decimal counting
  output logic [15:0] dec1,      // value minus one
  output logic [15:0] dec2       // value minus two
);

  // ==========================================================
  // one step, wrapping 0 to 0xFFFF or 9999
  function automatic logic [15:0] dec_one(input logic [15:0] v,
                                          input logic b);
    logic [15:0] r;
    logic brw;
    r = v - 16'h0001;
    brw = 1'b1;
    if (b) begin
      r = v;
      for (int i = 0; i < 4; i++) begin
        if (brw) begin
          if (r[4*i+:4] == 4'h0) begin
            r[4*i+:4] = 4'h9;
          end else begin
            r[4*i+:4] = r[4*i+:4] - 4'h1;
            brw = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  always_comb begin
    dec1 = dec_one(val, bcd);
    dec2 = dec_one(dec_one(val, bcd), bcd);
  end

endmodule

// File: verilog/pcm_pkg.sv
// constants, encodings and register map of the counter channel
package pcm_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CNT = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_CE = 8'h14;
  localparam logic [7:0] OFF_HOLD = 8'h18;

  // ==========================================================
  // control word fields
  localparam int CW_BCD = 0;
  localparam int CW_MODE = 1;
  localparam int CW_AW = 4;
  localparam int CW_W = 6;

  localparam logic [2:0] M_TC = 3'h0;
  localparam logic [2:0] M_OS = 3'h1;
  localparam logic [2:0] M_RATE = 3'h2;
  localparam logic [2:0] M_SQ = 3'h3;
  localparam logic [2:0] M_SWS = 3'h4;
  localparam logic [2:0] M_HWS = 3'h5;

  localparam logic [1:0] AW_NONE = 2'h0;
  localparam logic [1:0] AW_LOW = 2'h1;
  localparam logic [1:0] AW_HIGH = 2'h2;
  localparam logic [1:0] AW_BOTH = 2'h3;

  // ==========================================================
  // event bits and reset values
  localparam int EV_TC = 0;
  localparam int EV_TRIG = 1;
  localparam int EV_W = 2;

  localparam logic [5:0] RST_CTRL = 6'h00;
  localparam logic [15:0] RST_CE = 16'h0000;
  localparam logic [15:0] RST_HOLD = 16'h0000;
  localparam logic [1:0] RST_EV = 2'h0;
  localparam logic RST_OUT = 1'b1;

  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_TWO = 16'h0002;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } pcm_state_t;

endpackage
